// ==== rtl/osc_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the oscillator control block
// Assumes: 32-bit classic Wishbone register bus, byte addressed
// Notes: Field positions, offsets, reset values and timing counts

package osc_ctrl_pkg;

	// ==================================================================
	// Register offsets
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_CLEAR = 4'h4;
	localparam logic [3:0] OFS_SET = 4'h8;
	localparam logic [3:0] OFS_INVERT = 4'hC;
	localparam logic [3:0] OFS_CFG1 = 4'h0;
	localparam logic [3:0] OFS_CFG2 = 4'h4;

	// ==================================================================
	// Control register field positions
	localparam int POS_PLL_ODIV = 27;
	localparam int POS_RC_DIV = 24;
	localparam int POS_SEC_READY = 22;
	localparam int POS_BUS_DIV_READY = 21;
	localparam int POS_BUS_DIV = 19;
	localparam int POS_PLL_MULT = 16;
	localparam int POS_CUR_SRC = 12;
	localparam int POS_NEXT_SRC = 8;
	localparam int POS_SEL_LOCK = 7;
	localparam int POS_USB_LOCK = 6;
	localparam int POS_SYS_LOCK = 5;
	localparam int POS_SLEEP = 4;
	localparam int POS_FAIL = 3;
	localparam int POS_SWITCH = 0;

	// Implemented, writable and freezable bits
	localparam logic [31:0] MASK_WRITABLE = 32'h3F1F0799;
	localparam logic [31:0] MASK_FROZEN = 32'h38070700;

	// ==================================================================
	// Boot configuration field positions
	localparam int POS_CFG_INIT_SRC = 0;
	localparam int POS_CFG_MONITOR = 14;
	localparam int POS_CFG_BUS_DIV = 12;
	localparam int POS_CFG_PLL_ODIV = 16;
	localparam int POS_CFG_PLL_MULT = 4;

	// ==================================================================
	// Fixed reset values
	localparam logic [2:0] RST_RC_DIV = 3'h1;
	localparam logic RST_BUS_DIV_READY = 1'b1;

	// ==================================================================
	// Timing
	localparam int CLK_HZ = 10000000;
	localparam int SWITCH_TIME_US = 10;
	localparam int SWITCH_CYCLES = (SWITCH_TIME_US * (CLK_HZ / 1000000));
	localparam int BUS_DIV_TIME_US = 2;
	localparam int BUS_DIV_CYCLES = (BUS_DIV_TIME_US * (CLK_HZ / 1000000));

	// ==================================================================
	// Unlock keys
	localparam logic [31:0] UNLOCK_KEY1 = 32'hAA996655;
	localparam logic [31:0] UNLOCK_KEY2 = 32'h556699AA;

	typedef enum logic [1:0] {
		ULK_IDLE = 2'h0,
		ULK_KEY1 = 2'h1,
		ULK_OPEN = 2'h3
	} unlock_type;

	typedef enum logic [1:0] {
		SW_IDLE = 2'h0,
		SW_WAIT = 2'h1,
		SW_DONE = 2'h3
	} switch_type;

endpackage : osc_ctrl_pkg

// ==== rtl/osc_divider.sv ====
// Purpose: Power-of-two clock enable divider for one clock path
// Assumes: Code n selects divide by 2^n, last code divides by 2^8 when LAST_SHIFT is 8
// Notes: Output is a one-cycle tick per divided period

`timescale 1ns/1ps

module osc_divider #(
	parameter int CODE_W = 3,
	parameter int LAST_SHIFT = 8
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic [CODE_W-1:0] code,
	output logic tick
);

	typedef struct packed {
		logic [8:0] count;
		logic tick;
	} state_type;

	state_type r;
	state_type next_r;

	// ==================================================================
	// Code to terminal count
	function automatic logic [8:0] span(input logic [CODE_W-1:0] c);
		logic [8:0] s;
		s = 9'h001;
		if (c == {CODE_W{1'b1}} && LAST_SHIFT == 8) begin
			s = 9'h100;
		end else begin
			s = 9'(9'h001 << c);
		end
		return s;
	endfunction : span

	always_comb begin
		next_r = r;
		if (r.count + 9'h001 >= span(code)) begin
			next_r.count = 9'h000;
			next_r.tick = 1'b1;
		end else begin
			next_r.count = r.count + 9'h001;
			next_r.tick = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;

endmodule : osc_divider

// ==== rtl/osc_control.sv ====
// Purpose: Oscillator control and status register with clock dividers
// Assumes: Classic Wishbone slave, analog status arrives asynchronously
// Notes: One wait-state-free answer one cycle after the request
//        Boot words are captured once, at the first edge after reset
//        Status inputs pass a two-stage synchroniser before use
//
// Decided for this implementation: the address map and the Wishbone register port.

`timescale 1ns/1ps

module osc_control
	import osc_ctrl_pkg::*;
#(
	parameter int SWITCH_WAIT = SWITCH_CYCLES,
	parameter int BUS_DIV_WAIT = BUS_DIV_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [31:0] BOOT_CFG1,
	input wire logic [31:0] BOOT_CFG2,
	input wire logic SEC_OSC_STABLE,
	input wire logic SYS_PLL_LOCK_IN,
	input wire logic USB_PLL_LOCK_IN,
	input wire logic FAIL_DETECT,
	input wire logic WAIT_EXEC,
	output logic [2:0] ACTIVE_SOURCE,
	output logic [2:0] PLL_MULT_CODE,
	output logic PLL_OUT_TICK,
	output logic RC_OUT_TICK,
	output logic BUS_CLK_TICK,
	output logic SLEEP_ENTER,
	output logic IDLE_ENTER,
	output logic SWITCH_BUSY
);
	import osc_ctrl_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		unlock_type ulk;
		switch_type sw;
		logic [15:0] sw_cnt;
		logic [15:0] pb_cnt;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic fail_prev;
		logic ack;
		logic [31:0] rdata;
		logic sleep;
		logic idle;
		logic [2:0] mult;
		logic boot_done;
		logic lock_honoured;
		logic pll_en;
		logic rc_en;
		logic pb_en;
	} state_type;

	state_type r;
	state_type next_r;
	logic pll_tick;
	logic rc_tick;
	logic pb_tick;

	// ==================================================================
	// Byte-lane merge
	function automatic logic [31:0] lanes(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lanes

	// ==================================================================
	// Control, clear, set and invert write views
	function automatic logic [31:0] merge(input logic [3:0] o,
		input logic [31:0] cur, input logic [31:0] d,
		input logic [31:0] m);
		logic [31:0] v;
		v = cur;
		case (o)
			OFS_CONTROL: v = (cur & ~m) | (d & m);
			OFS_CLEAR: v = cur & ~(d & m);
			OFS_SET: v = cur | (d & m);
			OFS_INVERT: v = cur ^ (d & m);
			default: v = cur;
		endcase
		return v;
	endfunction : merge

	// ==================================================================
	// Readable image, unimplemented bits forced low
	function automatic logic [31:0] read_view(input logic [31:0] c);
		logic [31:0] v;
		v = c & (MASK_WRITABLE | 32'h00677060);
		v[31:30] = 2'b00;
		v[23] = 1'b0;
		v[15] = 1'b0;
		v[11] = 1'b0;
		return v;
	endfunction : read_view

	// ==================================================================
	// Dividers
	osc_divider #(.CODE_W(3), .LAST_SHIFT(8)) u_pll_div (
		.CLK_SYS(CLK_SYS),
		.RSTN(RSTN),
		.code(r.ctrl[POS_PLL_ODIV +: 3]),
		.tick(pll_tick)
	);

	osc_divider #(.CODE_W(3), .LAST_SHIFT(8)) u_rc_div (
		.CLK_SYS(CLK_SYS),
		.RSTN(RSTN),
		.code(r.ctrl[POS_RC_DIV +: 3]),
		.tick(rc_tick)
	);

	osc_divider #(.CODE_W(2), .LAST_SHIFT(3)) u_pb_div (
		.CLK_SYS(CLK_SYS),
		.RSTN(RSTN),
		.code(r.ctrl[POS_BUS_DIV +: 2]),
		.tick(pb_tick)
	);

	// ==================================================================
	// Register and sequencing logic
	always_comb begin
		logic sel_bus;
		logic ctrl_hit;
		logic wr;
		logic rd;
		logic frozen;
		logic [31:0] wmask;
		logic [31:0] wdata;
		logic [31:0] newv;
		logic [3:0] ofs;
		logic sec_ok;
		logic sys_ok;
		logic usb_ok;
		logic fail_now;
		next_r = r;
		sec_ok = r.sync2[0];
		sys_ok = r.sync2[1];
		usb_ok = r.sync2[2];
		fail_now = r.sync2[3];
		sel_bus = WB_CYC_I && WB_STB_I && !r.ack;
		ofs = {WB_ADR_I[3:2], 2'b00};
		ctrl_hit = !WB_ADR_I[4];
		wr = sel_bus && WB_WE_I;
		rd = sel_bus && !WB_WE_I;
		wmask = lanes(WB_SEL_I);
		wdata = WB_DAT_I;
		newv = r.ctrl;
		frozen = r.ctrl[POS_SEL_LOCK] &&
			r.lock_honoured;

		next_r.sync1 = {FAIL_DETECT, USB_PLL_LOCK_IN, SYS_PLL_LOCK_IN,
			SEC_OSC_STABLE};
		next_r.sync2 = r.sync1;
		next_r.ack = sel_bus;
		next_r.sleep = 1'b0;
		next_r.idle = 1'b0;

		// ==========================================================
		// Boot-derived fields after reset release
		if (!r.boot_done) begin
			next_r.boot_done = 1'b1;
			next_r.lock_honoured = BOOT_CFG1[POS_CFG_MONITOR + 1];
			next_r.ctrl[POS_NEXT_SRC +: 3] =
				BOOT_CFG1[POS_CFG_INIT_SRC +: 3];
			next_r.ctrl[POS_CUR_SRC +: 3] = BOOT_CFG1[POS_CFG_INIT_SRC +: 3];
			next_r.ctrl[POS_BUS_DIV +: 2] = BOOT_CFG1[POS_CFG_BUS_DIV +: 2];
			next_r.ctrl[POS_PLL_ODIV +: 3] = BOOT_CFG2[POS_CFG_PLL_ODIV +: 3];
			next_r.ctrl[POS_PLL_MULT +: 3] = BOOT_CFG2[POS_CFG_PLL_MULT +: 3];
		end

		// ==========================================================
		// Status bits follow synchronised inputs
		next_r.ctrl[POS_SEC_READY] = sec_ok;
		next_r.ctrl[POS_SYS_LOCK] = sys_ok;
		next_r.ctrl[POS_USB_LOCK] = usb_ok;

		// ==========================================================
		// Read data and read side effect
		if (rd) begin
			if (ctrl_hit && ofs == OFS_CONTROL) begin
				next_r.rdata = read_view(r.ctrl);
				next_r.ctrl[POS_FAIL] = 1'b0;
			end else if (!ctrl_hit && ofs == OFS_CFG1) begin
				next_r.rdata = BOOT_CFG1;
			end else if (!ctrl_hit && ofs == OFS_CFG2) begin
				next_r.rdata = BOOT_CFG2;
			end else begin
				next_r.rdata = 32'h00000000;
			end
		end

		// ==========================================================
		// Unlock sequence and aliased writes
		if (wr && !ctrl_hit) begin
			next_r.ulk = ULK_IDLE;
		end
		if (wr && ctrl_hit) begin
			case (r.ulk)
				ULK_IDLE: begin
					if (WB_DAT_I == UNLOCK_KEY1 && ofs == OFS_CONTROL &&
						WB_SEL_I == 4'hF) begin
						next_r.ulk = ULK_KEY1;
					end
				end
				ULK_KEY1: begin
					if (WB_DAT_I == UNLOCK_KEY2 && ofs == OFS_CONTROL &&
						WB_SEL_I == 4'hF) begin
						next_r.ulk = ULK_OPEN;
					end else begin
						next_r.ulk = ULK_IDLE;
					end
				end
				ULK_OPEN: begin
					next_r.ulk = ULK_IDLE;
					newv = merge(ofs, r.ctrl, wdata, wmask);
					if (frozen) begin
						newv = (newv & ~MASK_FROZEN) | (r.ctrl & MASK_FROZEN);
					end
					if (!r.ctrl[POS_BUS_DIV_READY]) begin
						newv[POS_BUS_DIV +: 2] = r.ctrl[POS_BUS_DIV +: 2];
					end
					if (r.sw != SW_IDLE) begin
						newv[POS_SWITCH] = 1'b1;
					end
					next_r.ctrl = (next_r.ctrl & ~MASK_WRITABLE) |
						(newv & MASK_WRITABLE);
					if (newv[POS_BUS_DIV +: 2] != r.ctrl[POS_BUS_DIV +: 2]) begin
						next_r.ctrl[POS_BUS_DIV_READY] = 1'b0;
						next_r.pb_cnt = 16'(BUS_DIV_WAIT);
					end
				end
				default: next_r.ulk = ULK_IDLE;
			endcase
		end

		// ==========================================================
		// Divisor ready returns after settling
		if (!r.ctrl[POS_BUS_DIV_READY] && next_r.pb_cnt == r.pb_cnt) begin
			if (r.pb_cnt <= 16'h0001) begin
				next_r.ctrl[POS_BUS_DIV_READY] = 1'b1;
				next_r.pb_cnt = 16'h0000;
			end else begin
				next_r.pb_cnt = r.pb_cnt - 16'h0001;
			end
		end

		// ==========================================================
		// Fail flag set wins over read clear
		next_r.fail_prev = fail_now;
		if (fail_now && !r.fail_prev) begin
			next_r.ctrl[POS_FAIL] = 1'b1;
		end

		// ==========================================================
		// Clock switch sequencing
		case (r.sw)
			SW_IDLE: begin
				if (r.ctrl[POS_SWITCH]) begin
					next_r.sw = SW_WAIT;
					next_r.sw_cnt = 16'(SWITCH_WAIT);
				end
			end
			SW_WAIT: begin
				if (r.sw_cnt <= 16'h0001) begin
					next_r.sw = SW_DONE;
				end else begin
					next_r.sw_cnt = r.sw_cnt - 16'h0001;
				end
			end
			SW_DONE: begin
				next_r.sw = SW_IDLE;
				next_r.ctrl[POS_CUR_SRC +: 3] = r.ctrl[POS_NEXT_SRC +: 3];
				next_r.ctrl[POS_SWITCH] = 1'b0;
			end
			default: next_r.sw = SW_IDLE;
		endcase

		// ==========================================================
		// Wait instruction
		if (WAIT_EXEC) begin
			next_r.sleep = r.ctrl[POS_SLEEP];
			next_r.idle = !r.ctrl[POS_SLEEP];
		end
		next_r.mult = r.ctrl[POS_PLL_MULT +: 3];

		// ==========================================================
		// Divided clock enables, one more register stage
		next_r.pll_en = pll_tick;
		next_r.rc_en = rc_tick;
		next_r.pb_en = pb_tick;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			r <= '0;
			r.ctrl[POS_RC_DIV +: 3] <= RST_RC_DIV;
			r.ctrl[POS_BUS_DIV_READY] <= RST_BUS_DIV_READY;
			r.ulk <= ULK_IDLE;
			r.sw <= SW_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ==================================================================
	// Outputs
	assign WB_DAT_O = r.rdata;
	assign WB_ACK_O = r.ack;
	assign ACTIVE_SOURCE = r.ctrl[POS_CUR_SRC +: 3];
	assign PLL_MULT_CODE = r.mult;
	assign PLL_OUT_TICK = r.pll_en;
	assign RC_OUT_TICK = r.rc_en;
	assign BUS_CLK_TICK = r.pb_en;
	assign SLEEP_ENTER = r.sleep;
	assign IDLE_ENTER = r.idle;
	assign SWITCH_BUSY = r.ctrl[POS_SWITCH];

endmodule : osc_control

// ==== tb/osc_control_chk.sv ====
// Purpose: Port assertions for osc_control
// Assumes: Status inputs change slowly
// Notes: Bound to every osc_control instance
`timescale 1ns/1ps
module osc_control_chk (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic SEC_OSC_STABLE,
	input wire logic SYS_PLL_LOCK_IN,
	input wire logic USB_PLL_LOCK_IN,
	input wire logic WAIT_EXEC,
	input wire logic [2:0] ACTIVE_SOURCE,
	input wire logic SLEEP_ENTER,
	input wire logic IDLE_ENTER,
	input wire logic SWITCH_BUSY
);
	// ====
	// Read sequences
	default clocking dc @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	sequence s_rd;
		WB_ACK_O && !WB_WE_I && WB_ADR_I[4] == 1'b0;
	endsequence
	sequence s_ctl;
		s_rd ##0 WB_ADR_I[3:2] == 2'h0;
	endsequence
	// ====
	// Properties
	property p_rsv;
		s_rd |-> WB_DAT_O[31:30] == 2'h0 && !WB_DAT_O[23] && !WB_DAT_O[15]
			&& !WB_DAT_O[11];
	endproperty
	property p_alias;
		s_rd ##0 WB_ADR_I[3:2] != 2'h0 |-> WB_DAT_O == 32'h0;
	endproperty
	property p_sec;
		(!SEC_OSC_STABLE) [*7] ##0 s_ctl |-> !WB_DAT_O[22];
	endproperty
	property p_sys;
		SYS_PLL_LOCK_IN [*7] ##0 s_ctl |-> WB_DAT_O[5];
	endproperty
	property p_usb;
		(!USB_PLL_LOCK_IN) [*7] ##0 s_ctl |-> !WB_DAT_O[6];
	endproperty
	property p_wait;
		WAIT_EXEC |=> SLEEP_ENTER != IDLE_ENTER;
	endproperty
	property p_cur;
		$past(RSTN, 2) && $changed(ACTIVE_SOURCE) |-> $fell(SWITCH_BUSY);
	endproperty
	property p_sw;
		$rose(SWITCH_BUSY) |-> ##[1:40] !SWITCH_BUSY;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	a_alias: assert property (p_alias) else $error("alias read");
	a_sec: assert property (p_sec) else $error("secondary ready");
	a_sys: assert property (p_sys) else $error("pll lock");
	a_usb: assert property (p_usb) else $error("usb lock");
	a_wait: assert property (p_wait) else $error("wait mode");
	a_cur: assert property (p_cur) else $error("source early");
	a_sw: assert property (p_sw) else $error("switch stuck");
endmodule : osc_control_chk
bind osc_control osc_control_chk u_chk (.CLK_SYS, .RSTN, .WB_WE_I,
	.WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .SEC_OSC_STABLE, .SYS_PLL_LOCK_IN,
	.USB_PLL_LOCK_IN, .WAIT_EXEC, .ACTIVE_SOURCE, .SLEEP_ENTER,
	.IDLE_ENTER, .SWITCH_BUSY);

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for osc_control
// Assumes: Short switch wait, divisor wait twice the default
// Notes: Classic Wishbone master tasks
`timescale 1ns/1ps
module testbench;
	import osc_ctrl_pkg::*;
	logic clk, rstn, cyc, stb, we, sec, sys, usb, fail, wx;
	logic ack, slp, idl, swb, pt, rt, bt;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, cfg1, cfg2, q;
	logic [2:0] asrc, pmc;
	int miscompares, cmp_count;
	osc_control #(.SWITCH_WAIT(4), .BUS_DIV_WAIT(40)) uut (.CLK_SYS(clk),
		.RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .BOOT_CFG1(cfg1), .BOOT_CFG2(cfg2),
		.SEC_OSC_STABLE(sec), .SYS_PLL_LOCK_IN(sys), .USB_PLL_LOCK_IN(usb),
		.FAIL_DETECT(fail), .WAIT_EXEC(wx), .ACTIVE_SOURCE(asrc),
		.PLL_MULT_CODE(pmc), .PLL_OUT_TICK(pt), .RC_OUT_TICK(rt),
		.BUS_CLK_TICK(bt), .SLEEP_ENTER(slp), .IDLE_ENTER(idl),
		.SWITCH_BUSY(swb));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ====
	// Common tasks
	task summarize;
		$display("errors=%0d checks=%0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			miscompares++;
			summarize();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rd(input logic [4:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task unl(input logic [4:0] a, input logic [31:0] d);
		wb(1'b1, 5'h00, UNLOCK_KEY1);
		wb(1'b1, 5'h00, UNLOCK_KEY2);
		wb(1'b1, a, d);
	endtask : unl
	task rst;
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : rst
	task wexec(input logic e);
		@(posedge clk);
		wx <= 1'b1;
		@(posedge clk);
		wx <= 1'b0;
		@(posedge clk);
		chk(slp, e);
		chk(idl, !e);
	endtask : wexec
	// ====
	// Scenarios
	task t_boot;
		int np, nr, nb;
		np = 0;
		nr = 0;
		nb = 0;
		rd(5'h00, 32'h293E2200);
		chk(asrc, 3'h2);
		chk(pmc, 3'h6);
		rd(5'h10, cfg1);
		rd(5'h04, 32'h0);
		repeat (256) begin
			@(posedge clk);
			np += pt;
			nr += rt;
			nb += bt;
		end
		chk(np, 8);
		chk(nr, 128);
		chk(nb, 32);
	endtask : t_boot
	task t_unlock;
		wb(1'b1, 5'h08, 32'h10);
		rd(5'h00, 32'h293E2200);
		unl(5'h08, 32'h10);
		rd(5'h00, 32'h293E2210);
		wexec(1'b1);
		unl(5'h04, 32'h10);
		wexec(1'b0);
	endtask : t_unlock
	task t_switch;
		int n;
		n = 0;
		unl(5'h08, 32'h80);
		unl(5'h0C, 32'h700);
		rd(5'h00, 32'h293E2280);
		unl(5'h04, 32'h80);
		unl(5'h0C, 32'h700);
		unl(5'h08, 32'h1);
		@(posedge clk);
		chk(swb, 1'b1);
		while (swb !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk(swb, 1'b0);
		chk(asrc, 3'h5);
		rd(5'h00, 32'h293E5500);
	endtask : t_switch
	task t_busdiv;
		int nb;
		nb = 0;
		unl(5'h04, 32'h00180000);
		rd(5'h00, 32'h29065500);
		repeat (40) @(posedge clk);
		rd(5'h00, 32'h29265500);
		repeat (64) begin
			@(posedge clk);
			nb += bt;
		end
		chk(nb, 64);
	endtask : t_busdiv
	task t_status;
		sec <= 1'b1;
		sys <= 1'b1;
		usb <= 1'b1;
		fail <= 1'b1;
		repeat (8) @(posedge clk);
		rd(5'h00, 32'h29665568);
		rd(5'h00, 32'h29665560);
		sec <= 1'b0;
		usb <= 1'b0;
		fail <= 1'b0;
	endtask : t_status
	task t_free;
		cfg1 <= 32'h00003002;
		rst();
		unl(5'h08, 32'h80);
		unl(5'h0C, 32'h700);
		rd(5'h00, 32'h293E25A0);
	endtask : t_free
	initial begin
		miscompares = 0;
		cmp_count = 0;
		{cyc, stb, we, sec, sys, usb, fail, wx} = 8'h00;
		adr = 5'h00;
		sel = 4'hF;
		wdat = 32'h0;
		cfg1 = 32'h0000B002;
		cfg2 = 32'h00050060;
		rstn = 1'b0;
		rst();
		t_boot();
		t_unlock();
		t_switch();
		t_busdiv();
		t_status();
		t_free();
		summarize();
	end
endmodule : testbench
